//--- hdl/fpla_cell_regs.svh
// Fuse positions, field offsets and status addresses of the macrocell fabric.
// Assumes the configuration port addresses single fuse bits by fuse number.
`ifndef FPLA_CELL_REGS_SVH
`define FPLA_CELL_REGS_SVH

`define ADDR_W 14
`define DATA_W 32

// Cell counts
`define NUM_DED_INPUTS 10
`define NUM_PIN_CELLS 10
`define NUM_HIDDEN_CELLS 8

// Hidden cell n: three fuses from 8154 + 3n
`define FUSE_HIDDEN_BASE 14'h1FDA
`define FUSE_HIDDEN_STRIDE 3
`define FUSE_HIDDEN_LAST 14'h1FF1

// Pin-driving cell n: four fuses from 8178 + 4n, cell 9 ends at 8217
`define FUSE_PIN_BASE 14'h1FF2
`define FUSE_PIN_STRIDE 4
`define FUSE_PIN_LAST 14'h2019

// Input sections
`define FUSE_DED_SYNC 14'h201A
`define FUSE_DED_LATCH 14'h201B
`define FUSE_PIN_IN_SYNC 14'h201C
`define FUSE_PIN_IN_LATCH 14'h201D
`define FUSE_LAST 14'h201D

// Fuse store: index = fuse number - first fuse
`define CFG_BITS 68
`define CFG_IDX_W 7
`define CFG_PIN_BASE_IDX 24
`define CFG_DED_SYNC_IDX 64
`define CFG_DED_LATCH_IDX 65
`define CFG_PIN_IN_SYNC_IDX 66
`define CFG_PIN_IN_LATCH_IDX 67

// Field offsets inside one cell's fuse group
`define FLD_CLK_SEL 0
`define FLD_SYNC_SEL 1
`define FLD_EN_POL 2
`define FLD_DATA_POL 3

// Status words, read only
`define ADDR_STAT_PIN_CELLS 14'h0000
`define ADDR_STAT_HIDDEN 14'h0001
`define ADDR_STAT_INPUTS 14'h0002

`endif

//--- hdl/fpla_pkg.sv
// Types shared by the macrocell fabric and its cells.
// Assumes the fuse layout of fpla_cell_regs.svh.
package fpla_pkg;

  typedef struct packed {
    logic data_term_polarity;
    logic enable_term_polarity;
    logic cell_sync_select;
    logic clk_sel;
  } cell_cfg_t;

  typedef enum logic [2:0] {
    CELL_COMB = 3'h1,
    CELL_SUMCLK = 3'h2,
    CELL_CLKEN = 3'h4
  } cell_mode_t;

  typedef enum logic [2:0] {
    IN_ASYNC = 3'h1,
    IN_LATCH = 3'h2,
    IN_REG = 3'h4
  } in_mode_t;

  typedef struct packed {
    logic [9:0] data;
    logic [9:0] enable;
    logic [9:0] oe;
  } pin_terms_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] enable;
  } hidden_terms_t;

  typedef struct packed {
    logic [9:0] ded_in;
    logic [9:0] pin_in;
    logic [9:0] pin_cell;
    logic [7:0] hidden_true;
    logic [7:0] hidden_comp;
  } feedback_t;

  function automatic cell_mode_t cell_mode_of(input cell_cfg_t cfg);
    if (!cfg.cell_sync_select) begin
      return CELL_COMB;
    end
    return cfg.clk_sel ? CELL_CLKEN : CELL_SUMCLK;
  endfunction : cell_mode_of

  function automatic in_mode_t input_mode_of(input logic sync_sel, input logic latch_sel);
    if (!sync_sel) begin
      return IN_ASYNC;
    end
    return latch_sel ? IN_LATCH : IN_REG;
  endfunction : input_mode_of

endpackage : fpla_pkg

//--- hdl/logic_cell.sv
// One buried or pin-driving macrocell: polarity XORs, three modes, shared reset.
// Assumes one system clock; the output-side clock arrives as a one-cycle rise pulse.
`timescale 1ns/1ps
`default_nettype none

module logic_cell (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire fpla_pkg::cell_cfg_t i_cfg,
  input wire logic i_data_term,
  input wire logic i_enable_term,
  input wire logic i_reset_term,
  input wire logic i_output_side_clock_rise,
  output logic o_value,
  output logic o_q
);
  import fpla_pkg::*;

  cell_mode_t mode;
  logic d_in;
  logic en_in;
  logic en_prev;
  logic q;

  assign mode = cell_mode_of(i_cfg);
  assign d_in = i_data_term ^ i_cfg.data_term_polarity;
  assign en_in = i_enable_term ^ i_cfg.enable_term_polarity;

  // Sum-term clock is seen as a rising edge of the polarised term
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= en_in;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= 1'b0;
    end else if (i_reset_term) begin
      q <= 1'b0;
    end else begin
      case (mode)
        CELL_CLKEN: begin
          if (i_output_side_clock_rise && en_in) begin
            q <= d_in;
          end
        end
        CELL_SUMCLK: begin
          if (en_in && !en_prev) begin
            q <= d_in;
          end
        end
        CELL_COMB: begin
          q <= q;
        end
        default: begin
          q <= q;
        end
      endcase
    end
  end

  // Reset term also masks q at once, so the clear is seen in the same cycle
  always_comb begin
    case (mode)
      CELL_COMB: o_value = d_in;
      CELL_SUMCLK, CELL_CLKEN: o_value = i_reset_term ? 1'b0 : q;
      default: o_value = d_in;
    endcase
  end

  assign o_q = q;

endmodule : logic_cell

`default_nettype wire

//--- hdl/fpla_macrocell_logic.sv
// Macrocell fabric around an external AND/OR array: two input sections,
// eight hidden state cells, ten pin-driving cells and the fuse store.
// Assumes the array's sum and product terms arrive as synchronous inputs,
// and both the input-side and output-side clocks are sampled on i_mclk.
`timescale 1ns/1ps
`default_nettype none

`include "fpla_cell_regs.svh"

// Overview of operation
// - Each input section runs as a whole: pass-through, latch, or register.
// - Input-side clock is latch enable when latched, register clock when registered.
// - Dedicated and pin input sections each keep their own mode.
// - Eight hidden state cells feed only the array, never a pin.
// - Ten pin-driving cells drive a pin and feed the array.
// - Each cell is combinatorial, sum-term clocked register, or clock-enable register.
// - Each pin is bidirectional; its own product term sets direction.
// - Pin cell data term passes a per-cell XOR for true or inverted output.
// - Every cell's enable/clock term passes a polarity XOR.
// - Hidden cells give both true and complemented outputs to the array.
// - Clock-enable mode loads on output-side clock only while enable is true.
// - Sum-term clock mode: always enabled, enable term clocks the register.
// - One active-high reset term clears all cell registers to zero.
// - A cleared register shows as one at its pin through the inverting buffer.
// - Pin cells always feed their value back from before the buffer.
// - Pins also feed back through the pin input section.
// - Dedicated inputs use fuses 8218, 8219; pin inputs use 8220, 8221.
// - Pin cell n has four fuses from 8178 plus 4n, ending at 8217.
// - Hidden cell n has three fuses from 8154 plus 3n, ending at 8177.
module fpla_macrocell_logic (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [13:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_input_side_clock,
  input wire logic i_output_side_clock,
  input wire logic [9:0] i_ded_pin,
  input wire logic [9:0] i_io_pin,
  output logic [9:0] o_io_pin,
  output logic [9:0] o_io_oe,
  input wire fpla_pkg::pin_terms_t i_pin_terms,
  input wire fpla_pkg::hidden_terms_t i_hidden_terms,
  input wire logic i_reset_term,
  output fpla_pkg::feedback_t o_feedback
);
  import fpla_pkg::*;

  // Fuse store and bus
  logic [`CFG_BITS-1:0] cfg_bits;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic wr_hit;
  logic [`CFG_IDX_W-1:0] wr_idx;
  logic [`CFG_IDX_W-1:0] rd_idx;

  // Clock edge detection
  logic input_side_clock_prev;
  logic output_side_clock_prev;
  logic input_side_clock_rise;
  logic output_side_clock_rise;

  // Input sections
  in_mode_t ded_mode;
  in_mode_t pin_in_mode;
  logic [9:0] ded_held;
  logic [9:0] pin_in_held;
  logic [9:0] ded_value;
  logic [9:0] pin_in_value;

  // Cells
  cell_cfg_t pin_cfg [10];
  cell_cfg_t hidden_cfg [8];
  logic [9:0] pin_cell_value;
  logic [9:0] pin_cell_q;
  logic [7:0] hidden_value;
  logic [7:0] hidden_q;

  // Fuse number to store index; out-of-range numbers report a miss
  function automatic logic fuse_hit(input logic [13:0] addr);
    return (addr >= `FUSE_HIDDEN_BASE) && (addr <= `FUSE_LAST);
  endfunction : fuse_hit

  function automatic logic [`CFG_IDX_W-1:0] fuse_index(input logic [13:0] addr);
    logic [13:0] diff;
    diff = addr - `FUSE_HIDDEN_BASE;
    return diff[`CFG_IDX_W-1:0];
  endfunction : fuse_index

  // One input bit through its section: held value covers latch and register
  function automatic logic input_stage(
    input in_mode_t mode,
    input logic pin,
    input logic held,
    input logic input_side_clock
  );
    case (mode)
      IN_ASYNC: return pin;
      IN_LATCH: return input_side_clock ? pin : held;
      IN_REG: return held;
      default: return pin;
    endcase
  endfunction : input_stage

  function automatic logic [`CFG_IDX_W-1:0] cfg_idx(input int base, input int stride, input int n);
    int v;
    v = base + stride * n;
    return v[`CFG_IDX_W-1:0];
  endfunction : cfg_idx

  // One cell's fuse group from its first store index
  function automatic cell_cfg_t fuse_group(
    input logic [`CFG_BITS-1:0] bits,
    input logic [`CFG_IDX_W-1:0] first,
    input logic has_data_pol
  );
    cell_cfg_t c;
    c.clk_sel = bits[first + `CFG_IDX_W'(`FLD_CLK_SEL)];
    c.cell_sync_select = bits[first + `CFG_IDX_W'(`FLD_SYNC_SEL)];
    c.enable_term_polarity = bits[first + `CFG_IDX_W'(`FLD_EN_POL)];
    c.data_term_polarity = has_data_pol && bits[first + `CFG_IDX_W'(`FLD_DATA_POL)];
    return c;
  endfunction : fuse_group

  // Configuration writes. Fuses are meant to be static: rewriting them while
  // cells are registered may glitch a sum-term clock, so load before use.
  assign wr_hit = i_wr && fuse_hit(i_addr);
  assign wr_idx = fuse_index(i_addr);
  assign rd_idx = fuse_index(i_addr);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_bits <= '0;
    end else if (wr_hit) begin
      cfg_bits[wr_idx] <= i_wdata[0];
    end
  end

  // Registered cells read as cleared while the reset term is high
  always_comb begin
    status_word = 32'h0000_0000;
    case (i_addr)
      `ADDR_STAT_PIN_CELLS: status_word[9:0] = i_reset_term ? 10'h000 : pin_cell_q;
      `ADDR_STAT_HIDDEN: status_word[7:0] = i_reset_term ? 8'h00 : hidden_q;
      `ADDR_STAT_INPUTS: status_word[19:0] = {pin_in_held, ded_held};
      default: status_word = 32'h0000_0000;
    endcase
  end

  // Read returns fuse bits or live status; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      if (fuse_hit(i_addr)) begin
        next_rdata[0] = cfg_bits[rd_idx];
      end else begin
        next_rdata = status_word;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Both clocks are ordinary synchronous inputs, so one stage finds the edge
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      input_side_clock_prev <= 1'b0;
    end else begin
      input_side_clock_prev <= i_input_side_clock;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      output_side_clock_prev <= 1'b0;
    end else begin
      output_side_clock_prev <= i_output_side_clock;
    end
  end

  assign input_side_clock_rise = i_input_side_clock && !input_side_clock_prev;
  assign output_side_clock_rise = i_output_side_clock && !output_side_clock_prev;

  // Input section modes, each from its own fuse pair
  assign ded_mode = input_mode_of(cfg_bits[`CFG_DED_SYNC_IDX],
                                  cfg_bits[`CFG_DED_LATCH_IDX]);
  assign pin_in_mode = input_mode_of(cfg_bits[`CFG_PIN_IN_SYNC_IDX],
                                     cfg_bits[`CFG_PIN_IN_LATCH_IDX]);

  // Dedicated input section holding stage
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ded_held <= 10'h000;
    end else begin
      case (ded_mode)
        IN_LATCH: begin
          if (i_input_side_clock) begin
            ded_held <= i_ded_pin;
          end
        end
        IN_REG: begin
          if (input_side_clock_rise) begin
            ded_held <= i_ded_pin;
          end
        end
        IN_ASYNC: begin
          ded_held <= ded_held;
        end
        default: begin
          ded_held <= ded_held;
        end
      endcase
    end
  end

  // Pin input section holding stage
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_in_held <= 10'h000;
    end else begin
      case (pin_in_mode)
        IN_LATCH: begin
          if (i_input_side_clock) begin
            pin_in_held <= i_io_pin;
          end
        end
        IN_REG: begin
          if (input_side_clock_rise) begin
            pin_in_held <= i_io_pin;
          end
        end
        IN_ASYNC: begin
          pin_in_held <= pin_in_held;
        end
        default: begin
          pin_in_held <= pin_in_held;
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_DED_INPUTS; i++) begin
      ded_value[i] = input_stage(ded_mode, i_ded_pin[i], ded_held[i],
                                 i_input_side_clock);
    end
  end

  // Pin levels return through this section whatever the drive direction
  always_comb begin
    for (int i = 0; i < `NUM_PIN_CELLS; i++) begin
      pin_in_value[i] = input_stage(pin_in_mode, i_io_pin[i], pin_in_held[i],
                                    i_input_side_clock);
    end
  end

  // Fuse groups of the pin-driving cells
  always_comb begin
    for (int n = 0; n < `NUM_PIN_CELLS; n++) begin
      pin_cfg[n] = fuse_group(cfg_bits, cfg_idx(`CFG_PIN_BASE_IDX, `FUSE_PIN_STRIDE, n),
                              1'b1);
    end
  end

  // Hidden cells have no data polarity fuse; polarity is chosen in the array
  always_comb begin
    for (int n = 0; n < `NUM_HIDDEN_CELLS; n++) begin
      hidden_cfg[n] = fuse_group(cfg_bits, cfg_idx(0, `FUSE_HIDDEN_STRIDE, n),
                                 1'b0);
    end
  end

  // Ten pin-driving cells, mode per cell from its sync and clock fuses
  for (genvar g = 0; g < `NUM_PIN_CELLS; g++) begin : g_pin_cell
    logic_cell u_cell (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_cfg(pin_cfg[g]),
      .i_data_term(i_pin_terms.data[g]),
      .i_enable_term(i_pin_terms.enable[g]),
      .i_reset_term(i_reset_term),
      .i_output_side_clock_rise(output_side_clock_rise),
      .o_value(pin_cell_value[g]),
      .o_q(pin_cell_q[g])
    );
  end

  // Eight hidden state cells
  for (genvar g = 0; g < `NUM_HIDDEN_CELLS; g++) begin : g_hidden_cell
    logic_cell u_cell (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_cfg(hidden_cfg[g]),
      .i_data_term(i_hidden_terms.data[g]),
      .i_enable_term(i_hidden_terms.enable[g]),
      .i_reset_term(i_reset_term),
      .i_output_side_clock_rise(output_side_clock_rise),
      .o_value(hidden_value[g]),
      .o_q(hidden_q[g])
    );
  end

  // Pins: inverting buffer, direction from each cell's own product term
  assign o_io_pin = ~pin_cell_value;
  assign o_io_oe = i_pin_terms.oe;

  // Feedback into the array; hidden cells never reach a pin
  assign o_feedback.ded_in = ded_value;
  assign o_feedback.pin_in = pin_in_value;
  assign o_feedback.pin_cell = pin_cell_value;
  assign o_feedback.hidden_true = hidden_value;
  assign o_feedback.hidden_comp = ~hidden_value;

endmodule : fpla_macrocell_logic

`default_nettype wire

//--- tb/fpla_macrocell_monitor.sv
// Checker of port relations of the macrocell fabric.
// Assumes it is bound onto fpla_macrocell_logic with one clock, i_mclk.
`timescale 1ns/1ps
`default_nettype none
`include "fpla_cell_regs.svh"
module fpla_macrocell_monitor (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [13:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [9:0] o_io_pin,
  input wire logic [9:0] o_io_oe,
  input wire fpla_pkg::pin_terms_t i_pin_terms,
  input wire logic i_reset_term,
  input wire fpla_pkg::feedback_t o_feedback
);
  import fpla_pkg::*;
  wire logic fuse_a;
  assign fuse_a = (i_addr >= `FUSE_HIDDEN_BASE) && (i_addr <= `FUSE_LAST);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  a_oe_follows_term: assert property (o_io_oe == i_pin_terms.oe)
    else $error("pin enable differs from its term");
  a_pin_inverted: assert property (o_io_pin == ~o_feedback.pin_cell)
    else $error("pin drive is not the inverted cell value");
  a_hidden_both: assert property (o_feedback.hidden_comp == ~o_feedback.hidden_true)
    else $error("hidden cell complement is wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (i_rd && !fuse_a && i_addr > 14'h0002
    |=> o_rdata == 32'h0000_0000) else $error("unmapped read is not zero");
  a_rdata_narrow: assert property (i_rd && fuse_a |=> o_rdata[31:1] == 31'h0000_0000)
    else $error("fuse read wider than one bit");
  a_fuse_readback: assert property (i_wr && fuse_a ##2 i_rd && i_addr == $past(i_addr, 2)
    |=> o_rdata[0] == $past(i_wdata[0], 3)) else $error("fuse does not read back");
  a_reset_clears: assert property ($past(i_reset_term) && i_rd && i_addr < 14'h0002
    |=> o_rdata == 32'h0000_0000) else $error("cell registers not cleared");
endmodule : fpla_macrocell_monitor
bind fpla_macrocell_logic fpla_macrocell_monitor u_mon (.i_mclk, .i_rst_b, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_io_pin, .o_io_oe, .i_pin_terms, .i_reset_term, .o_feedback);
`default_nettype wire

//--- tb/board_pins.sv
// Board model for the bidirectional pins: the fabric or the board drives each line.
// Assumes no pull resistors, so an undriven line shows the inverse of the board value.
`timescale 1ns/1ps
`default_nettype none
module board_pins (
  input wire logic [9:0] i_drive,
  input wire logic [9:0] i_oe,
  input wire logic [9:0] i_board_val,
  input wire logic [9:0] i_board_oe,
  output logic [9:0] o_level
);
  always_comb begin
    for (int b = 0; b < 10; b++) begin
      if (i_oe[b]) begin
        o_level[b] = i_drive[b];
      end else if (i_board_oe[b]) begin
        o_level[b] = i_board_val[b];
      end else begin
        o_level[b] = ~i_board_val[b];
      end
    end
  end
endmodule : board_pins
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the macrocell fabric: fuse port, cells, input sections.
// Assumes the board model resolves the bidirectional pins.
`timescale 1ns/1ps
`default_nettype none
`include "fpla_cell_regs.svh"
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module testbench;
  import fpla_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic input_side_clock = 1'b0;
  logic output_side_clock = 1'b0;
  logic [9:0] ded = '0;
  logic [9:0] board = '0;
  logic [9:0] board_oe = '0;
  logic rst_term = 1'b0;
  pin_terms_t pt = '0;
  hidden_terms_t ht = '0;
  logic [31:0] rdata;
  logic [9:0] pin_lvl, pin_drv, pin_oe;
  feedback_t fb;
  int fail_count = 0;
  int samples_checked = 0;
  fpla_macrocell_logic uut (.i_mclk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_input_side_clock(input_side_clock),
    .i_output_side_clock(output_side_clock), .i_ded_pin(ded), .i_io_pin(pin_lvl), .o_io_pin(pin_drv),
    .o_io_oe(pin_oe), .i_pin_terms(pt), .i_hidden_terms(ht), .i_reset_term(rst_term),
    .o_feedback(fb));
  board_pins u_board (.i_drive(pin_drv), .i_oe(pin_oe), .i_board_val(board),
    .i_board_oe(board_oe), .o_level(pin_lvl));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr_f(input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_f
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  // Output clock rise with cell 0 terms set one edge earlier
  task automatic ce_load(input logic d, input logic e);
    @(posedge clk);
    output_side_clock <= 1'b0;
    pt.data[0] <= d;
    pt.enable[0] <= e;
    @(posedge clk);
    output_side_clock <= 1'b1;
    settle();
  endtask : ce_load
  task automatic st_load(input logic d);
    @(posedge clk);
    ht.enable[0] <= 1'b0;
    ht.data[0] <= d;
    @(posedge clk);
    ht.enable[0] <= 1'b1;
    settle();
  endtask : st_load
  task automatic input_side_clock_rise();
    @(posedge clk);
    input_side_clock <= 1'b0;
    @(posedge clk);
    input_side_clock <= 1'b1;
    settle();
  endtask : input_side_clock_rise
  initial begin
    forever #50 clk = ~clk;
  end
  // A hang ends the run as a failure
  initial begin
    #3_000_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int f = 8154; f <= 8221; f++) begin
      wr_f(14'(f), 32'hffff_ffff);
      rd_chk(14'(f), 32'h0000_0001);
      wr_f(14'(f), 32'h0000_0000);
    end
    wr_f(14'h1fd9, 32'h0000_0001);
    rd_chk(`FUSE_HIDDEN_BASE, 32'h0000_0000);
    wr_f(14'h201e, 32'h0000_0001);
    rd_chk(14'h201e, 32'h0000_0000);
    rd_chk(`FUSE_LAST, 32'h0000_0000);
    @(posedge clk);
    pt.data <= 10'h2a5;
    pt.oe <= 10'h0f0;
    ht.data <= 8'h5a;
    ded <= 10'h155;
    board <= 10'h3c3;
    board_oe <= 10'h30f;
    settle();
    `CHK(fb.pin_cell, 10'h2a5)
    `CHK(pin_drv, 10'h15a)
    `CHK(pin_oe, 10'h0f0)
    `CHK(fb.ded_in, 10'h155)
    `CHK(fb.pin_in, 10'h353)
    `CHK(fb.hidden_comp, 8'ha5)
    @(posedge clk);
    ht.data <= 8'ha5;
    settle();
    `CHK(pin_drv, 10'h15a)
    `CHK(fb.hidden_true, 8'ha5)
    wr_f(14'h1ff5, 32'h0000_0001);
    settle();
    `CHK(fb.pin_cell, 10'h2a4)
    wr_f(14'h1ff5, 32'h0000_0000);
    wr_f(14'h1ff2, 32'h0000_0001);
    wr_f(14'h1ff3, 32'h0000_0001);
    ce_load(1'b1, 1'b0);
    `CHK(fb.pin_cell[0], 1'b0)
    ce_load(1'b1, 1'b1);
    `CHK(fb.pin_cell[0], 1'b1)
    @(posedge clk);
    pt.data[0] <= 1'b0;
    settle();
    settle();
    `CHK(fb.pin_cell[0], 1'b1)
    wr_f(14'h1ff4, 32'h0000_0001);
    ce_load(1'b0, 1'b1);
    `CHK(fb.pin_cell[0], 1'b1)
    ce_load(1'b1, 1'b0);
    `CHK(fb.pin_cell[0], 1'b1)
    ce_load(1'b0, 1'b0);
    `CHK(fb.pin_cell[0], 1'b0)
    ce_load(1'b1, 1'b0);
    wr_f(14'h1fdb, 32'h0000_0001);
    st_load(1'b1);
    `CHK(fb.hidden_true[0], 1'b1)
    @(posedge clk);
    ht.data[0] <= 1'b0;
    settle();
    `CHK(fb.hidden_true[0], 1'b1)
    st_load(1'b0);
    `CHK(fb.hidden_true[0], 1'b0)
    st_load(1'b1);
    // Reset term checked in the very cycle it rises: the cell output masks q before the synchronous clear
    @(posedge clk);
    rst_term <= 1'b1;
    rd <= 1'b1;
    addr <= `ADDR_STAT_HIDDEN;
    @(negedge clk);
    `CHK(fb.pin_cell[0], 1'b0)
    `CHK(pin_drv[0], 1'b1)
    `CHK(fb.hidden_true[0], 1'b0)
    `CHK(fb.pin_cell[2], 1'b1)
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, 32'h0000_0000)
    rd_chk(`ADDR_STAT_PIN_CELLS, 32'h0000_0000);
    @(posedge clk);
    rst_term <= 1'b0;
    settle();
    `CHK(fb.pin_cell[0], 1'b0)
    wr_f(14'h201a, 32'h0000_0001);
    wr_f(14'h201c, 32'h0000_0001);
    wr_f(14'h201d, 32'h0000_0001);
    @(posedge clk);
    pt.oe <= 10'h000;
    board_oe <= 10'h3ff;
    board <= 10'h3c3;
    input_side_clock_rise();
    `CHK(fb.ded_in, 10'h155)
    `CHK(fb.pin_in, 10'h3c3)
    @(posedge clk);
    ded <= 10'h0aa;
    board <= 10'h2d2;
    settle();
    `CHK(fb.ded_in, 10'h155)
    `CHK(fb.pin_in, 10'h2d2)
    @(posedge clk);
    board <= 10'h111;
    input_side_clock <= 1'b0;
    settle();
    `CHK(fb.pin_in, 10'h2d2)
    input_side_clock_rise();
    `CHK(fb.ded_in, 10'h0aa)
    `CHK(fb.pin_in, 10'h111)
    // Swap the section modes: dedicated latched, pin registered
    wr_f(14'h201b, 32'h0000_0001);
    wr_f(14'h201d, 32'h0000_0000);
    @(posedge clk);
    ded <= 10'h321;
    board <= 10'h0f0;
    settle();
    `CHK(fb.ded_in, 10'h321)
    `CHK(fb.pin_in, 10'h111)
    @(posedge clk);
    input_side_clock <= 1'b0;
    ded <= 10'h00f;
    settle();
    `CHK(fb.ded_in, 10'h321)
    `CHK(fb.pin_in, 10'h111)
    input_side_clock_rise();
    `CHK(fb.ded_in, 10'h00f)
    `CHK(fb.pin_in, 10'h0f0)
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
